// ==== inc/dma_gc_cfg.svh ====
// Purpose: register map, field positions, reset values and sizes of the dma global control block
// Assumes: apb byte addresses, one 32-bit word per register
// Notes: the package holds the types, this header the numbers
// Function
// R1: with global enable clear no channel moves data until software sets it again
// R2: software sets the global enable before programming channels or starting transfers
// R3: error status reads non-zero while a bus error is pending, else zero
// R4: a write to error clear removes the pending error; handler clears after inspecting
// R5: channel interrupt status is 32 bits, one per channel, several may be set
// R6: writing a mask clears status of channels with mask bit one, others kept
// R7: own interrupt carries software channel completion and errors only
// R8: software aligns the control table to 1024 bytes; full table is 1024 bytes
// R9: run-to-completion channel keeps moving after its first request until count exhausted
// R10: software channel is enabled first, then an explicit software request starts it; here req_sync on its bit also starts it
// R11: channel attributes reset cleared; software channel needs none for memory copies
// R12: at transfer end mode becomes stopped and the channel enable clears itself
// R13: size field counts remaining items and reads zero once complete
// R14: error flag and channel status bits stay set until software clears them
`ifndef DMA_GC_CFG_SVH
`define DMA_GC_CFG_SVH

`define DMA_OFS_CTRL 12'h000
`define DMA_OFS_STATUS 12'h004
`define DMA_OFS_TABLE_BASE 12'h008
`define DMA_OFS_SW_REQ 12'h00C
`define DMA_OFS_EN_SET 12'h010
`define DMA_OFS_EN_CLR 12'h014
`define DMA_OFS_ATTR_SET 12'h018
`define DMA_OFS_ATTR_CLR 12'h01C
`define DMA_OFS_CH_SEL 12'h020
`define DMA_OFS_CH_CTRL 12'h024
`define DMA_OFS_CH_INT_STATUS 12'h028
`define DMA_OFS_ERR_STATUS 12'h02C
`define DMA_OFS_ERR_CLR 12'h030
`define DMA_OFS_IRQ_STATUS 12'h034
`define DMA_OFS_IRQ_MASK 12'h038

`define DMA_CTRL_EN_BIT 0
`define DMA_STATUS_BUSY_BIT 1
`define DMA_TABLE_ALIGN_BITS 10
`define DMA_CH_CTRL_MODE_LSB 0
`define DMA_CH_CTRL_MODE_MSB 1
`define DMA_CH_CTRL_SIZE_LSB 8
`define DMA_CH_CTRL_SIZE_MSB 18
`define DMA_IRQ_SW_DONE_BIT 0
`define DMA_IRQ_ERR_BIT 1
`define DMA_IRQ_BITS 2
`define DMA_RST_CTRL 1'b0
`define DMA_RST_IRQ_MASK 2'h0
`define DMA_SW_CHANNEL 30
`define DMA_NUM_CH 32
`define DMA_SIZE_W 11

`endif

// ==== inc/dma_gc_pkg.sv ====
// Purpose: shared types of the dma global control block
// Assumes: included after dma_gc_cfg.svh
// Notes: mode codes are the values software writes to the channel control field
`include "dma_gc_cfg.svh"

package dma_gc_pkg;
  typedef enum logic [1:0] {
    stopped_mode = 2'h0,
    basic_mode = 2'h1,
    run_to_completion_mode = 2'h2
  } xfer_mode_e;

  typedef logic [`DMA_SIZE_W-1:0] item_count_t;
  typedef logic [4:0] chan_idx_t;
endpackage

// ==== inc/dma_engine_if.sv ====
// Purpose: link between the control logic and the item engine
// Assumes: one clock domain
// Notes: go and done are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface dma_engine_if;
  logic go;
  dma_gc_pkg::chan_idx_t chan;
  dma_gc_pkg::item_count_t count;
  logic auto_run;
  logic run_en;
  logic busy;
  logic done;
  logic err;
  dma_gc_pkg::chan_idx_t done_chan;
  dma_gc_pkg::item_count_t remaining;

  modport ctl (output go, chan, count, auto_run, run_en,
               input busy, done, err, done_chan, remaining);
  modport eng (input go, chan, count, auto_run, run_en,
               output busy, done, err, done_chan, remaining);
endinterface
`default_nettype wire

// ==== core/dma_item_engine.sv ====
// Purpose: moves items of one granted channel over the item port
// Assumes: item port is on clk_sys_in, ready and error are sampled together
// Notes: basic mode moves one item per grant, run-to-completion drains the count
`timescale 1ns/1ps
`default_nettype none
module dma_item_engine (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  dma_engine_if.eng eng,
  output logic item_valid_out,
  output dma_gc_pkg::chan_idx_t item_channel_out,
  input wire logic item_ready_in,
  input wire logic item_err_in
);
  typedef enum logic {eng_idle, eng_move} eng_state_e;
  eng_state_e state;
  logic auto_q;
  dma_gc_pkg::item_count_t left;
  dma_gc_pkg::item_count_t left_dec;
  logic beat;

  assign left_dec = left - dma_gc_pkg::item_count_t'(1);
  // a cleared global enable drops item_valid_out at once, even for an item still waiting for ready
  assign item_valid_out = (state == eng_move) && eng.run_en; // R1
  assign beat = item_valid_out && item_ready_in;
  assign eng.busy = (state == eng_move);
  assign eng.done_chan = item_channel_out;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state <= eng_idle;
    end else begin
      unique case (state)
        eng_idle: if (eng.go) state <= eng_move;
        eng_move: if (beat && (item_err_in || left_dec == '0 || !auto_q)) state <= eng_idle; // R9
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      left <= '0;
      auto_q <= 1'b0;
      item_channel_out <= '0;
    end else if (state == eng_idle && eng.go) begin
      left <= eng.count;
      auto_q <= eng.auto_run;
      item_channel_out <= eng.chan;
    end else if (beat && !item_err_in) begin
      left <= left_dec; // R13
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      eng.done <= 1'b0;
      eng.err <= 1'b0;
      eng.remaining <= '0;
    end else begin
      eng.done <= beat && (item_err_in || left_dec == '0 || !auto_q);
      eng.err <= beat && item_err_in;
      eng.remaining <= item_err_in ? left : left_dec;
    end
  end
endmodule // dma_item_engine
`default_nettype wire

// ==== core/dma_global_control.sv ====
// Purpose: apb register file, channel table, arbitration and interrupts of the dma controller
// Assumes: apb master on clk_sys_in, peripheral requests arrive asynchronously
// Notes: zero wait state slave, read data captured in the setup cycle
//        channel state is held in flops; the table in memory is only addressed
`timescale 1ns/1ps
`default_nettype none
`include "dma_gc_cfg.svh"

module dma_global_control #(
  parameter int SW_CHANNEL = `DMA_SW_CHANNEL
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [31:0] periph_req_in,
  output logic [31:0] periph_done_out,
  output logic item_valid_out,
  output logic [4:0] item_channel_out,
  input wire logic item_ready_in,
  input wire logic item_err_in,
  output logic [31:0] table_base_out,
  output logic irq_out
);
  localparam int NCH = `DMA_NUM_CH;

  dma_engine_if eif ();

  logic [31:0] req_meta;
  logic [31:0] req_sync;
  logic global_en;
  logic [31:`DMA_TABLE_ALIGN_BITS] table_base;
  logic [31:0] chan_en;
  logic [31:0] attr;
  logic [31:0] sw_pend;
  logic [4:0] ch_sel;
  dma_gc_pkg::xfer_mode_e mode_mem [NCH];
  dma_gc_pkg::item_count_t size_mem [NCH];
  logic [31:0] ch_int_status;
  logic err_flag;
  logic [`DMA_IRQ_BITS-1:0] irq_status;
  logic [`DMA_IRQ_BITS-1:0] irq_mask;
  logic [`DMA_IRQ_BITS-1:0] irq_read_clr;
  logic wr_stb;
  logic rd_setup;
  logic err_clr_wr;
  logic [31:0] next_rdata;
  logic next_slverr;
  logic [31:0] cand;
  logic [31:0] mode_live;
  logic [31:0] prio_cand;
  logic [5:0] pick;
  logic launch;
  logic go_q;
  logic fin_ok;
  logic fin_err;
  logic fin_last;
  logic [31:0] fin_onehot;
  logic [31:0] launch_onehot;
  logic sw_done_evt;

  // lowest set bit, bit 5 flags that one was found
  function automatic logic [5:0] first_set(input logic [31:0] v);
    logic [5:0] r;
    r = 6'h00;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction

  // requests come from other clock domains
  // only req_sync feeds the arbiter; req_meta may still be settling
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      req_meta <= 32'h0000_0000;
      req_sync <= 32'h0000_0000;
    end else begin
      req_meta <= periph_req_in;
      req_sync <= req_meta;
    end
  end

  // no wait states: every access phase completes at its first edge
  assign pready_out = 1'b1;
  assign wr_stb = psel_in && penable_in && pwrite_in;
  assign rd_setup = psel_in && !penable_in && !pwrite_in;
  // any write to the clear address counts, its data is ignored
  assign err_clr_wr = wr_stb && paddr_in == `DMA_OFS_ERR_CLR;

  // global control
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      global_en <= `DMA_RST_CTRL;
    end else if (wr_stb && paddr_in == `DMA_OFS_CTRL) begin
      global_en <= pwdata_in[`DMA_CTRL_EN_BIT]; // R1
    end
  end

  // low bits are forced zero so the table is always 1024-byte aligned
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      table_base <= '0;
    end else if (wr_stb && paddr_in == `DMA_OFS_TABLE_BASE) begin
      table_base <= pwdata_in[31:`DMA_TABLE_ALIGN_BITS]; // R8
    end
  end
  assign table_base_out = {table_base, {`DMA_TABLE_ALIGN_BITS{1'b0}}};

  // channel pointer for the per-channel control window
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ch_sel <= 5'h00;
    end else if (wr_stb && paddr_in == `DMA_OFS_CH_SEL) begin
      ch_sel <= pwdata_in[4:0];
    end
  end

  // attributes only reorder arbitration; reset leaves them all clear
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      attr <= 32'h0000_0000; // R11
    end else if (wr_stb && paddr_in == `DMA_OFS_ATTR_SET) begin
      attr <= attr | pwdata_in;
    end else if (wr_stb && paddr_in == `DMA_OFS_ATTR_CLR) begin
      attr <= attr & ~pwdata_in;
    end
  end

  // arbitration
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      // the spare mode code acts as stop, so it can never launch
      mode_live[i] = (mode_mem[i] == dma_gc_pkg::basic_mode)
                     || (mode_mem[i] == dma_gc_pkg::run_to_completion_mode);
      cand[i] = chan_en[i] && mode_live[i]
                && size_mem[i] != '0 && (sw_pend[i] || req_sync[i]);
    end
  end
  assign prio_cand = (|(cand & attr)) ? (cand & attr) : cand;
  assign pick = first_set(prio_cand);
  // go_q and done hold off the next grant until the last writeback has landed
  assign launch = global_en && !eif.busy && !go_q && !eif.done && pick[5]; // R1
  assign launch_onehot = launch ? (32'h0000_0001 << pick[4:0]) : 32'h0000_0000;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      go_q <= 1'b0;
    end else begin
      go_q <= launch;
    end
  end

  assign eif.go = launch;
  assign eif.chan = pick[4:0];
  assign eif.count = size_mem[pick[4:0]];
  assign eif.auto_run = (mode_mem[pick[4:0]] == dma_gc_pkg::run_to_completion_mode); // R9
  assign eif.run_en = global_en; // R1

  // a software request pends any enabled channel, and req_sync can start the software channel too; a grant consumes it
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      sw_pend <= 32'h0000_0000;
    end else if (wr_stb && paddr_in == `DMA_OFS_SW_REQ) begin
      sw_pend <= (sw_pend & ~launch_onehot) | (pwdata_in & chan_en); // R10
    end else begin
      sw_pend <= sw_pend & ~launch_onehot;
    end
  end

  // completion writeback
  assign fin_ok = eif.done && !eif.err;
  assign fin_err = eif.done && eif.err;
  assign fin_last = fin_ok && eif.remaining == '0;
  assign fin_onehot = 32'h0000_0001 << eif.done_chan;

  // hardware clear at completion wins over a software set in the same cycle
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      chan_en <= 32'h0000_0000;
    end else begin
      if (wr_stb && paddr_in == `DMA_OFS_EN_SET) begin
        chan_en <= (chan_en | pwdata_in) & ~((fin_last || fin_err) ? fin_onehot : 32'h0); // R12
      end else if (wr_stb && paddr_in == `DMA_OFS_EN_CLR) begin
        // a clear write racing a completion must not keep the finished channel on
        chan_en <= chan_en & ~pwdata_in & ~((fin_last || fin_err) ? fin_onehot : 32'h0); // R12
      end else if (fin_last || fin_err) begin
        chan_en <= chan_en & ~fin_onehot; // R12
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      for (int i = 0; i < NCH; i++) begin
        mode_mem[i] <= dma_gc_pkg::stopped_mode;
        size_mem[i] <= '0;
      end
    end else begin
      if (wr_stb && paddr_in == `DMA_OFS_CH_CTRL) begin
        mode_mem[ch_sel] <= dma_gc_pkg::xfer_mode_e'(
          pwdata_in[`DMA_CH_CTRL_MODE_MSB:`DMA_CH_CTRL_MODE_LSB]);
        size_mem[ch_sel] <= pwdata_in[`DMA_CH_CTRL_SIZE_MSB:`DMA_CH_CTRL_SIZE_LSB];
      end
      if (eif.done) begin
        size_mem[eif.done_chan] <= eif.remaining; // R13
      end
      // completion comes last so it overrides a same-cycle control write
      if (fin_last || fin_err) begin
        mode_mem[eif.done_chan] <= dma_gc_pkg::stopped_mode; // R12
      end
    end
  end

  // channel and error status
  // set wins over a write-one-to-clear in the same cycle; reads never clear
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ch_int_status <= 32'h0000_0000;
    end else if (wr_stb && paddr_in == `DMA_OFS_CH_INT_STATUS) begin
      ch_int_status <= (ch_int_status & ~pwdata_in) | (fin_last ? fin_onehot : 32'h0); // R6
    end else if (fin_last) begin
      ch_int_status <= ch_int_status | fin_onehot; // R5 R14
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      err_flag <= 1'b0;
    end else if (fin_err) begin
      err_flag <= 1'b1; // R3 R14
    end else if (err_clr_wr) begin
      err_flag <= 1'b0; // R4
    end
  end

  // peripheral channels report completion through their own peripheral, never through irq_out
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      periph_done_out <= 32'h0000_0000;
    end else begin
      periph_done_out <= (fin_last && eif.done_chan != 5'(SW_CHANNEL)) ? fin_onehot
                         : 32'h0000_0000; // R7
    end
  end

  // interrupt summary
  assign sw_done_evt = fin_last && eif.done_chan == 5'(SW_CHANNEL); // R7

  // only bits actually returned by the read are cleared, so a late event survives
  assign irq_read_clr = (psel_in && penable_in && !pwrite_in
                         && paddr_in == `DMA_OFS_IRQ_STATUS)
                        ? prdata_out[`DMA_IRQ_BITS-1:0] : '0;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      irq_status <= '0;
    end else begin
      irq_status[`DMA_IRQ_SW_DONE_BIT] <= sw_done_evt
        || (irq_status[`DMA_IRQ_SW_DONE_BIT] && !irq_read_clr[`DMA_IRQ_SW_DONE_BIT]); // R7
      irq_status[`DMA_IRQ_ERR_BIT] <= fin_err
        || (irq_status[`DMA_IRQ_ERR_BIT] && !irq_read_clr[`DMA_IRQ_ERR_BIT]
            && !err_clr_wr); // R4 R7
    end
  end

  // mask resets clear: no interrupt until software opts in
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      irq_mask <= `DMA_RST_IRQ_MASK;
    end else if (wr_stb && paddr_in == `DMA_OFS_IRQ_MASK) begin
      irq_mask <= pwdata_in[`DMA_IRQ_BITS-1:0];
    end
  end

  // level output, so a handler that runs late still sees the request
  assign irq_out = |(irq_status & irq_mask);

  // read path
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_slverr = 1'b0;
    unique case (paddr_in)
      `DMA_OFS_CTRL: next_rdata[`DMA_CTRL_EN_BIT] = global_en;
      `DMA_OFS_STATUS: begin
        next_rdata[`DMA_CTRL_EN_BIT] = global_en;
        next_rdata[`DMA_STATUS_BUSY_BIT] = eif.busy;
      end
      `DMA_OFS_TABLE_BASE: next_rdata = table_base_out;
      `DMA_OFS_SW_REQ: next_rdata = sw_pend;
      `DMA_OFS_EN_SET, `DMA_OFS_EN_CLR: next_rdata = chan_en;
      `DMA_OFS_ATTR_SET, `DMA_OFS_ATTR_CLR: next_rdata = attr;
      `DMA_OFS_CH_SEL: next_rdata[4:0] = ch_sel;
      `DMA_OFS_CH_CTRL: begin
        next_rdata[`DMA_CH_CTRL_MODE_MSB:`DMA_CH_CTRL_MODE_LSB] = mode_mem[ch_sel];
        next_rdata[`DMA_CH_CTRL_SIZE_MSB:`DMA_CH_CTRL_SIZE_LSB] = size_mem[ch_sel]; // R13
      end
      `DMA_OFS_CH_INT_STATUS: next_rdata = ch_int_status; // R5
      `DMA_OFS_ERR_STATUS: next_rdata[0] = err_flag; // R3
      `DMA_OFS_ERR_CLR: next_rdata = 32'h0000_0000;
      `DMA_OFS_IRQ_STATUS: next_rdata[`DMA_IRQ_BITS-1:0] = irq_status;
      `DMA_OFS_IRQ_MASK: next_rdata[`DMA_IRQ_BITS-1:0] = irq_mask;
      default: next_slverr = 1'b1;
    endcase
  end

  // frozen at setup, so a read-clear only drops the bits software was given
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_out <= next_rdata;
    end
  end

  // unmapped addresses answer with an error in the access cycle
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pslverr_out <= 1'b0;
    end else if (psel_in && !penable_in) begin
      pslverr_out <= next_slverr;
    end
  end

  // one granted channel at a time moves through the item engine
  dma_item_engine dma_item_engine_i (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .eng(eif.eng),
    .item_valid_out(item_valid_out),
    .item_channel_out(item_channel_out),
    .item_ready_in(item_ready_in),
    .item_err_in(item_err_in)
  );
endmodule // dma_global_control
`default_nettype wire

// ==== dv/dma_global_control_asserts.sv ====
// Purpose: port-level checks of the dma global control block
// Assumes: one clock, synchronous active-high reset
// Notes: global enable state is inferred from apb writes seen at the ports
`timescale 1ns/1ps
`default_nettype none
`include "dma_gc_cfg.svh"
module dma_global_control_checker #(
  parameter int SW_CHANNEL = `DMA_SW_CHANNEL
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [31:0] periph_done_out,
  input wire logic item_valid_out,
  input wire logic [4:0] item_channel_out,
  input wire logic item_ready_in,
  input wire logic [31:0] table_base_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  logic ctl_wr;
  logic hs;
  assign ctl_wr = psel_in && penable_in && pwrite_in && paddr_in == `DMA_OFS_CTRL;
  assign hs = item_valid_out && item_ready_in;

  a_pready_const: assert property (pready_out) else $error("pready low");
  a_unmapped_refused: assert property (psel_in && !penable_in && paddr_in > `DMA_OFS_IRQ_MASK
    |=> pslverr_out && ($past(pwrite_in) || prdata_out == 32'h0))
    else $error("unmapped access not refused");
  a_disable_stops_items: assert property (ctl_wr && !pwdata_in[0]
    |=> !item_valid_out [*2]) else $error("item offered while disabled");
  a_valid_held: assert property (item_valid_out && !item_ready_in && !ctl_wr
    |=> item_valid_out) else $error("item valid dropped unaccepted");
  a_channel_stable: assert property (item_valid_out && !item_ready_in && !ctl_wr
    |=> $stable(item_channel_out)) else $error("item channel changed while waiting");
  a_done_after_item: assert property (periph_done_out != 32'h0 |->
    ($past(hs, 2) && periph_done_out == 32'h1 << $past(item_channel_out, 2)) ||
    ($past(hs, 3) && periph_done_out == 32'h1 << $past(item_channel_out, 3)))
    else $error("completion without matching item");
  a_done_one_cycle: assert property (periph_done_out != 32'h0
    |=> periph_done_out == 32'h0) else $error("completion pulse too long");
  a_done_not_sw: assert property (!periph_done_out[SW_CHANNEL])
    else $error("software channel completion routed to peripheral");
  a_table_aligned: assert property (table_base_out[9:0] == 10'h0)
    else $error("table base not aligned");
endmodule // dma_global_control_checker

bind dma_global_control dma_global_control_checker #(.SW_CHANNEL(SW_CHANNEL)) checker_i (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .periph_done_out(periph_done_out), .item_valid_out(item_valid_out),
  .item_channel_out(item_channel_out), .item_ready_in(item_ready_in),
  .table_base_out(table_base_out));
`default_nettype wire

// ==== dv/test_dma_global_control.sv ====
// Purpose: self-checking bench of the dma global control block
// Assumes: apb master and item responder drive at rising edges
// Notes: responder stalls one cycle before accepting every item
`timescale 1ns/1ps
`default_nettype none
`include "dma_gc_cfg.svh"
module test_dma_global_control;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0;
  logic [31:0] periph_req_in = 32'h0;
  logic item_ready_in = 1'b0;
  logic item_err_in = 1'b0;
  logic err_arm = 1'b0;
  logic [31:0] prdata_out;
  logic [31:0] periph_done_out;
  logic [31:0] table_base_out;
  logic [31:0] rdq;
  logic [31:0] done_seen = 32'h0;
  logic [4:0] item_channel_out;
  logic [4:0] last_chan = 5'h0;
  logic pready_out, pslverr_out, item_valid_out, irq_out, slv;
  int n_items = 0;
  int cycles = 0;
  int n_mismatch = 0;
  int n_tests = 0;

  dma_global_control dma_global_control_i (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .periph_req_in(periph_req_in), .periph_done_out(periph_done_out),
    .item_valid_out(item_valid_out), .item_channel_out(item_channel_out),
    .item_ready_in(item_ready_in), .item_err_in(item_err_in),
    .table_base_out(table_base_out), .irq_out(irq_out));

  always #2.5 clk_sys_in = ~clk_sys_in;

  // item sink: a stall cycle before each accept keeps valid waiting
  always @(posedge clk_sys_in) begin
    item_ready_in <= item_valid_out && !item_ready_in;
    item_err_in <= item_valid_out && !item_ready_in && err_arm;
    if (item_valid_out && item_ready_in) begin
      n_items <= n_items + 1;
      last_chan <= item_channel_out;
    end
    done_seen <= done_seen | periph_done_out;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch = n_mismatch + 1;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch = n_mismatch + 1;
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    @(posedge clk_sys_in);
    while (pready_out !== 1'b1) begin
      @(posedge clk_sys_in);
    end
    rdq = prdata_out;
    slv = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdq, exp);
  endtask

  task automatic cfg(input logic [31:0] ch, input logic [31:0] mode, input logic [31:0] size);
    wr(`DMA_OFS_CH_SEL, ch);
    wr(`DMA_OFS_CH_CTRL, (size << 8) | mode);
    wr(`DMA_OFS_EN_SET, 32'h1 << ch);
  endtask

  task automatic wait_items(input int n);
    int k;
    k = 0;
    while (n_items < n && k < 300) begin
      @(posedge clk_sys_in);
      k++;
    end
    chk(n_items, n);
    repeat (4) @(posedge clk_sys_in);
  endtask

  task automatic t_reset;
    rd(`DMA_OFS_CH_INT_STATUS, 32'h0);
    rd(`DMA_OFS_ERR_STATUS, 32'h0);
    rd(`DMA_OFS_ATTR_SET, 32'h0);
    rd(`DMA_OFS_IRQ_MASK, 32'h0);
    wr(`DMA_OFS_TABLE_BASE, 32'h2000_0400);
    rd(`DMA_OFS_TABLE_BASE, 32'h2000_0400);
    chk(table_base_out, 32'h2000_0400);
    rd(12'h040, 32'h0);
    chk(slv, 32'h1);
    wr(`DMA_OFS_CTRL, 32'h1);
    wr(`DMA_OFS_EN_SET, 32'h0000_0001);
    rd(`DMA_OFS_EN_CLR, 32'h0000_0001);
    wr(`DMA_OFS_EN_CLR, 32'h0000_0001);
    rd(`DMA_OFS_EN_SET, 32'h0);
    wr(`DMA_OFS_IRQ_MASK, 32'h3);
    $display("test reset done");
  endtask

  task automatic t_sw_auto;
    int base;
    base = n_items;
    cfg(`DMA_SW_CHANNEL, 2, 3);
    repeat (10) @(posedge clk_sys_in);
    chk(n_items, base);
    wr(`DMA_OFS_SW_REQ, 32'h1 << `DMA_SW_CHANNEL);
    wait_items(base + 3);
    chk(last_chan, `DMA_SW_CHANNEL);
    rd(`DMA_OFS_CH_CTRL, 32'h0);
    rd(`DMA_OFS_EN_SET, 32'h0);
    rd(`DMA_OFS_CH_INT_STATUS, 32'h1 << `DMA_SW_CHANNEL);
    chk(irq_out, 32'h1);
    rd(`DMA_OFS_IRQ_STATUS, 32'h1);
    @(negedge clk_sys_in);
    chk(irq_out, 32'h0);
    wr(`DMA_OFS_CH_INT_STATUS, 32'h1 << `DMA_SW_CHANNEL);
    rd(`DMA_OFS_CH_INT_STATUS, 32'h0);
    $display("test software channel done");
  endtask

  task automatic t_disable;
    int base;
    base = n_items;
    cfg(`DMA_SW_CHANNEL, 2, 2);
    wr(`DMA_OFS_CTRL, 32'h0);
    wr(`DMA_OFS_SW_REQ, 32'h1 << `DMA_SW_CHANNEL);
    repeat (12) @(posedge clk_sys_in);
    chk(n_items, base);
    chk(item_valid_out, 32'h0);
    wr(`DMA_OFS_CTRL, 32'h1);
    wait_items(base + 2);
    rd(`DMA_OFS_IRQ_STATUS, 32'h1);
    wr(`DMA_OFS_CH_INT_STATUS, 32'hFFFF_FFFF);
    $display("test global disable done");
  endtask

  task automatic t_periph;
    int base;
    base = n_items;
    cfg(3, 1, 1);
    cfg(5, 1, 1);
    wr(`DMA_OFS_ATTR_SET, 32'h0000_0020);
    periph_req_in <= 32'h0000_0028;
    wait_items(base + 2);
    periph_req_in <= 32'h0;
    chk(last_chan, 32'h3);
    wr(`DMA_OFS_ATTR_CLR, 32'h0000_0020);
    rd(`DMA_OFS_ATTR_SET, 32'h0);
    chk(done_seen, 32'h0000_0028);
    rd(`DMA_OFS_CH_INT_STATUS, 32'h0000_0028);
    rd(`DMA_OFS_CH_INT_STATUS, 32'h0000_0028);
    chk(irq_out, 32'h0);
    wr(`DMA_OFS_CH_INT_STATUS, 32'h0000_0008);
    rd(`DMA_OFS_CH_INT_STATUS, 32'h0000_0020);
    wr(`DMA_OFS_CH_INT_STATUS, 32'h0000_0020);
    rd(`DMA_OFS_CH_INT_STATUS, 32'h0);
    $display("test peripheral channels done");
  endtask

  task automatic t_error;
    int base;
    base = n_items;
    err_arm <= 1'b1;
    cfg(`DMA_SW_CHANNEL, 2, 2);
    wr(`DMA_OFS_SW_REQ, 32'h1 << `DMA_SW_CHANNEL);
    wait_items(base + 1);
    err_arm <= 1'b0;
    rd(`DMA_OFS_ERR_STATUS, 32'h1);
    rd(`DMA_OFS_ERR_STATUS, 32'h1);
    // the failed item is not counted as moved, so both items remain
    rd(`DMA_OFS_CH_CTRL, 32'h0000_0200);
    chk(irq_out, 32'h1);
    rd(`DMA_OFS_IRQ_STATUS, 32'h2);
    @(negedge clk_sys_in);
    chk(irq_out, 32'h0);
    wr(`DMA_OFS_ERR_CLR, 32'h0);
    rd(`DMA_OFS_ERR_STATUS, 32'h0);
    $display("test bus error done");
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    t_reset();
    t_sw_auto();
    t_disable();
    t_periph();
    t_error();
    stop_test();
  end
endmodule // test_dma_global_control
`default_nettype wire
